// ### pwr_seq_consts.svh
// timing constants for the board power good sequencer
`ifndef PWR_SEQ_CONSTS_SVH
`define PWR_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS 20
`define TERM_DELAY_US 1000
`define CORE_DELAY_US 1000
`define MON_RESET_US 200000
`define TERM_DELAY_CYC ((`TERM_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_DELAY_CYC ((`CORE_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MON_RESET_CYC ((`MON_RESET_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### pwr_seq_pkg.sv
// types shared by the board power good sequencer
package pwr_seq_pkg;
  typedef enum logic [1:0]
  {
    st_off = 2'b00,
    st_term_wait = 2'b01,
    st_core_wait = 2'b10,
    st_on = 2'b11
  } seq_state_t;
  typedef struct packed
  {
    logic supply_good;
    logic termination_regulator_good;
    logic clocks_locked;
    logic cpu_regulator_good;
  } upstream_t;
endpackage

// ### board_power_good_sequencer.sv
// board power good and reset sequencer, single clock domain
//
// Summary of operation
// R1 - monitor reset driven ~200 ms, then input
// R2 - power-on reset restores monitor defaults
// R3 - delayed termination good 1 ms after
// R4 - delay only on rising termination good
// R5 - core enable 1 ms after delayed good
// R6 - vid good within 1 to 10 ms
// R7 - core enable at least 1 ms after vid
// R8 - supply good starts the reset sequence
// R9 - clock chips drive only locked clocks
// R10 - power good out only after lock
// R11 - cpu regulator good drives power ok
// R12 - supply good valid only while rails valid
// R13 - free-running counts; upstream loss drops all; code drops all but resume_well_reset_n, on supply or termination loss or a held-low monitor pin
`timescale 1ns/1ps
`include "pwr_seq_consts.svh"
module board_power_good_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int term_delay_cyc = `TERM_DELAY_CYC,
  parameter int core_delay_cyc = `CORE_DELAY_CYC,
  parameter int mon_reset_cyc = `MON_RESET_CYC
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire upstream_t upstream_pin,
  input wire logic monitor_reset_n_in,
  output logic monitor_reset_n_out,
  output logic monitor_reset_n_oe,
  output logic delayed_termination_good,
  output logic processor_vid_good_pin,
  output logic core_regulator_enable,
  output logic southbridge_power_ok_in,
  output logic southbridge_regulator_good_in,
  output logic resume_well_reset_n,
  output logic system_reset_n
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (term_delay_cyc < 1 || core_delay_cyc < 1 || mon_reset_cyc < 1 ||
      term_delay_cyc > 16777215 || core_delay_cyc > 16777215 ||
      mon_reset_cyc > 16777215)
  begin : g_bad_param
    $error("sequencer delay counts out of range");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  upstream_t up_meta;
  upstream_t up;
  logic mon_meta;
  logic mon_sync;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      up_meta <= '0;
      up <= '0;
      mon_meta <= 1'b0;
      mon_sync <= 1'b0;
    end
    else
    begin
      up_meta <= upstream_pin;
      up <= up_meta;
      mon_meta <= monitor_reset_n_in;
      mon_sync <= mon_meta;
    end
  end

  // ----------------------------------------
  // monitor reset: driven after power-up, then released to an input
  // ----------------------------------------
  logic [23:0] mon_cnt;
  logic mon_done;
  wire mon_cnt_end = (mon_cnt == 24'(mon_reset_cyc - 1));
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mon_cnt <= 24'h00_0000;
      mon_done <= 1'b0;
    end
    else if (!mon_done)
    begin
      mon_cnt <= mon_cnt + 24'h00_0001; // R1
      mon_done <= mon_cnt_end; // R1
    end
  end
  // released wire needs two sync edges before its level means anything
  logic [1:0] done_pipe;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      done_pipe <= 2'b00;
    end
    else
    begin
      done_pipe <= {done_pipe[0], mon_done};
    end
  end
  // driving low for the whole power-up window resets all monitor registers
  assign monitor_reset_n_out = 1'b0; // R2
  assign monitor_reset_n_oe = !mon_done; // R1

  // ----------------------------------------
  // sequencing state machine
  // ----------------------------------------
  // a monitor holding its reset pin low after release also holds the board off
  // without the pipe the stale low sample at release would drop the board
  wire rails_ok = up.supply_good && (mon_sync || !done_pipe[1]); // R8 R12
  wire term_ok = rails_ok && up.termination_regulator_good; // R13
  seq_state_t state;
  seq_state_t next_state;
  logic [23:0] cnt;
  wire term_end = (cnt == 24'(term_delay_cyc - 1));
  wire core_end = (cnt == 24'(core_delay_cyc - 1));
  always_comb
  begin
    next_state = state;
    case (state)
      st_off: if (term_ok) next_state = st_term_wait; // R8
      st_term_wait: if (!term_ok) next_state = st_off;
        else if (term_end) next_state = st_core_wait; // R3 R4 R6
      st_core_wait: if (!term_ok) next_state = st_off;
        else if (core_end) next_state = st_on; // R5 R7
      st_on: if (!term_ok) next_state = st_off; // R13
      default: next_state = st_off;
    endcase
  end
  // counter is free-running per state; cleared on every state change
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= st_off;
      cnt <= 24'h00_0000;
    end
    else
    begin
      state <= next_state;
      cnt <= (next_state != state) ? 24'h00_0000 : cnt + 24'h00_0001; // R13
    end
  end

  // ----------------------------------------
  // outputs; supply or termination loss drops all but resume_well_reset_n combinationally with the state
  // ----------------------------------------
  wire dtg = (state == st_core_wait || state == st_on) && term_ok; // R4 R13
  wire core_en = (state == st_on) && term_ok; // R5 R7
  // vid good follows delayed termination good on the same edge: 1 ms after termination good, well under 10 ms
  wire pwr_ok = core_en && up.clocks_locked && up.cpu_regulator_good; // R10 R11
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      delayed_termination_good <= 1'b0;
      processor_vid_good_pin <= 1'b0;
      core_regulator_enable <= 1'b0;
      southbridge_power_ok_in <= 1'b0;
      southbridge_regulator_good_in <= 1'b0;
      resume_well_reset_n <= 1'b0;
      system_reset_n <= 1'b0;
    end
    else
    begin
      delayed_termination_good <= dtg; // R3
      processor_vid_good_pin <= dtg; // R6
      core_regulator_enable <= core_en; // R5
      southbridge_power_ok_in <= pwr_ok; // R11
      southbridge_regulator_good_in <= pwr_ok; // R11
      resume_well_reset_n <= mon_done; // R8
      // clocks are trusted only once the generators report lock
      system_reset_n <= pwr_ok; // R9 R10
    end
  end

  // ----------------------------------------
  // assertion helpers: run lengths of the inputs to each delay
  // ----------------------------------------
  logic [23:0] term_run;
  logic [23:0] dtg_run;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      term_run <= 24'h00_0000;
      dtg_run <= 24'h00_0000;
    end
    else
    begin
      term_run <= !up.termination_regulator_good ? 24'h00_0000 :
        term_run + 24'(term_run != 24'hFF_FFFF);
      dtg_run <= !delayed_termination_good ? 24'h00_0000 :
        dtg_run + 24'(dtg_run != 24'hFF_FFFF);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence vid_rise_s;
    $rose(processor_vid_good_pin);
  endsequence
  sequence core_rise_s;
    $rose(core_regulator_enable);
  endsequence

  mon_drive_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
    monitor_reset_n_oe |-> !monitor_reset_n_out)
    else $error("monitor reset driven high");
  mon_release_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
    !monitor_reset_n_oe |=> !monitor_reset_n_oe)
    else $error("monitor reset re-driven after release");
  term_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R3
    $rose(delayed_termination_good) |-> $past(state, 2) == st_term_wait)
    else $error("delayed termination good rose without wait");
  term_count_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R4
    $rose(delayed_termination_good) |-> term_run >= 24'(term_delay_cyc))
    else $error("termination delay count wrong");
  core_count_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
    core_rise_s |-> dtg_run >= 24'(core_delay_cyc))
    else $error("core enable delay count wrong");
  vid_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R6
    processor_vid_good_pin == delayed_termination_good)
    else $error("vid good differs from delayed termination good");
  core_after_vid_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R7
    core_rise_s |-> processor_vid_good_pin && $past(processor_vid_good_pin, 2))
    else $error("core enabled without prior vid good");
  drop_all_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
    !term_ok |=> !delayed_termination_good && !core_regulator_enable)
    else $error("outputs held after upstream loss");
  lock_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R10
    $rose(southbridge_power_ok_in) |-> $past(up.clocks_locked))
    else $error("power ok before clock lock");
  vid_before_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R5
    vid_rise_s |-> !core_regulator_enable)
    else $error("core enable before vid good");
endmodule // board_power_good_sequencer

// ### pwr_partner_model.sv
// supply, regulator, clock chip and monitor wire model for the sequencer bench
`timescale 1ns/1ps
module pwr_partner_model
  import pwr_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic power_on,
  input wire logic lock_late,
  input wire logic core_en,
  input wire logic mon_out,
  input wire logic mon_oe,
  output upstream_t up,
  output logic mon_wire
);
  upstream_t st = '0;
  int lock_cnt = 0;
  assign up = st;
  // released wire floats up through the pull-up
  assign mon_wire = mon_oe ? mon_out : 1'b1;
  always @(posedge clk_sys)
  begin
    st.supply_good <= power_on;
    st.termination_regulator_good <= power_on & st.supply_good;
    lock_cnt <= power_on ? lock_cnt + 1 : 0;
    st.clocks_locked <= power_on && lock_cnt >= (lock_late ? 60 : 3);
    st.cpu_regulator_good <= power_on & core_en;
  end
endmodule // pwr_partner_model

// ### board_power_good_sequencer_tb_top.sv
// self-checking bench for the board power good sequencer
`timescale 1ns/1ps
module board_power_good_sequencer_tb_top
  import pwr_seq_pkg::*;
;
  localparam int term_cyc = 10;
  localparam int core_cyc = 10;
  localparam int mon_cyc = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic power_on = 1'b0;
  logic lock_late = 1'b0;
  upstream_t up;
  logic mon_wire, mon_out, mon_oe, dtg, vid, core_en, pok, vrg, rsm_n, sys_n;
  logic [2:0] watch;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  assign watch = {pok, core_en, dtg};
  board_power_good_sequencer #(.term_delay_cyc(term_cyc), .core_delay_cyc(core_cyc),
    .mon_reset_cyc(mon_cyc)) u_board_power_good_sequencer (.clk_sys(clk_sys), .rstn(rstn),
    .upstream_pin(up), .monitor_reset_n_in(mon_wire), .monitor_reset_n_out(mon_out),
    .monitor_reset_n_oe(mon_oe), .delayed_termination_good(dtg),
    .processor_vid_good_pin(vid), .core_regulator_enable(core_en),
    .southbridge_power_ok_in(pok), .southbridge_regulator_good_in(vrg),
    .resume_well_reset_n(rsm_n), .system_reset_n(sys_n));
  pwr_partner_model u_pwr_partner_model (.clk_sys(clk_sys), .power_on(power_on),
    .lock_late(lock_late), .core_en(core_en), .mon_out(mon_out), .mon_oe(mon_oe),
    .up(up), .mon_wire(mon_wire));
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic check(input logic seen, input logic exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask
  // bounded so a stuck output cannot hang the run
  task automatic wait_high(input int idx, output int k);
    k = 0;
    while (watch[idx] !== 1'b1 && k < 200)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic test_reset();
    repeat (4) @(negedge clk_sys);
    check(mon_oe, 1'b1, "monitor reset not driven");
    check(mon_out, 1'b0, "monitor reset drive level");
    check(dtg | core_en | pok | sys_n, 1'b0, "outputs live in reset");
    @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (mon_cyc - 2) @(negedge clk_sys);
    check(mon_oe, 1'b1, "monitor window short");
    repeat (5) @(negedge clk_sys);
    check(mon_oe, 1'b0, "monitor window long");
    check(rsm_n, 1'b1, "resume reset held");
    $display("test_reset done");
  endtask
  task automatic test_power(input logic late);
    @(posedge clk_sys);
    lock_late <= late;
    power_on <= 1'b1;
    wait_high(0, n);
    check(n == term_cyc + 7, 1'b1, "termination delay");
    check(vid, 1'b1, "vid good apart from delayed good");
    check(core_en, 1'b0, "core enable early");
    wait_high(1, n);
    check(n == core_cyc, 1'b1, "core delay");
    if (late)
      check(pok, 1'b0, "power ok before lock");
    wait_high(2, n);
    check(n < 60, 1'b1, "power ok late");
    check(up.clocks_locked, 1'b1, "power ok without lock");
    check(vrg, pok, "regulator good differs");
    check(sys_n, 1'b1, "system reset held");
    $display("test_power done");
  endtask
  task automatic test_drop();
    @(posedge clk_sys);
    power_on <= 1'b0;
    repeat (5) @(negedge clk_sys);
    check(dtg | vid | core_en | pok | sys_n, 1'b0, "outputs kept after loss");
    @(posedge clk_sys);
    power_on <= 1'b1;
    repeat (term_cyc) @(posedge clk_sys);
    power_on <= 1'b0;
    repeat (2 * term_cyc)
    begin
      @(negedge clk_sys);
      check(dtg, 1'b0, "short good pulse passed");
    end
    $display("test_drop done");
  endtask
  task automatic test_rerst();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check(mon_oe, 1'b1, "monitor not driven on reset");
    check(dtg | core_en | pok, 1'b0, "outputs kept in reset");
    @(posedge clk_sys);
    rstn <= 1'b1;
    // supply still up: sequencing starts inside the new monitor window; core enable rises after its release
    // release edge, 2 sync, 1 state, count, 1 register
    wait_high(0, n);
    check(n == term_cyc + 5, 1'b1, "termination delay after reset");
    wait_high(1, n);
    check(n == core_cyc, 1'b1, "core delay after reset");
    repeat (5) @(negedge clk_sys);
    check(core_en & dtg & pok, 1'b1, "outputs dropped at monitor release");
    check(mon_oe, 1'b0, "monitor still driven after reset");
    $display("test_rerst done");
  endtask
  // ------------------------------
  // clock, timeout and sequence
  // ------------------------------
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    test_reset();
    test_power(1'b0);
    test_drop();
    test_power(1'b1);
    test_rerst();
    results();
  end
endmodule // board_power_good_sequencer_tb_top
